// >>> verilog/wp_gate_pkg.sv
// Constants for the register write-protect gate
package wp_gate_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] WP_CTRL_ADDR = 8'h14;
  localparam logic [7:0] WP_CTRL_RESET = 8'h01;
  localparam int WP_EN_BIT = 0;
  localparam int RSVD_LO = 1;
  localparam int RSVD_HI = 3;
  localparam logic [3:0] BLANK_READ = 4'h0;
  localparam logic [2:0] RSVD_RESET = 3'h0;
  localparam logic WP_EN_RESET = 1'b1;
endpackage

// >>> verilog/wp_gate.sv
// Write-protect gate for the serial register interface
// Function
// RULE1: While protection is 1, register writes are dropped, contents unchanged.
// RULE2: While protection is 0, each register write commits its data byte.
// RULE3: STOP and reset both return protection to 1.
// RULE4: Bits 7..4 have no storage; host writes zeros, reads mean nothing.
// RULE5: Bits 3..1 reserved, reset 0, read/write with no effect.
// RULE6: Writes to the control register itself always commit; a same-cycle STOP still forces the enable bit to 1.
`timescale 1ns/1ps
module wp_gate (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic CE,
  input wire logic WR_STB,
  input wire logic [7:0] WR_ADDR,
  input wire logic [7:0] WR_DATA,
  input wire logic RD_STB,
  input wire logic [7:0] RD_ADDR,
  input wire logic STOP_DET,
  output logic REG_WR_STB,
  output logic [7:0] REG_WR_ADDR,
  output logic [7:0] REG_WR_DATA,
  output logic [7:0] RD_DATA,
  output logic RD_HIT,
  output logic WP_EN
);

  logic wp_en_q;
  logic [2:0] rsvd_q;
  logic ctrl_hit;
  logic pass;
  logic ctrl_wr;
  logic rd_ctrl;
  logic [7:0] rd_word;

  ////////////////////////////////////////////////////////////////////////
  // Decode and gating
  assign ctrl_hit = (WR_ADDR == wp_gate_pkg::WP_CTRL_ADDR);
  // Own register bypasses the gate so host can unlock mid-transaction
  assign pass = WR_STB && !ctrl_hit && !wp_en_q; // RULE1 RULE2
  assign WP_EN = wp_en_q;

  // Control write decode used by the checks; control read decode shared by logic and checks
  assign ctrl_wr = WR_STB && ctrl_hit; // RULE6
  assign rd_ctrl = RD_STB && (RD_ADDR == wp_gate_pkg::WP_CTRL_ADDR);
  // Blank bits have no flops; they read back as a fixed pattern
  assign rd_word = {wp_gate_pkg::BLANK_READ, rsvd_q, wp_en_q}; // RULE4

  ////////////////////////////////////////////////////////////////////////
  // Protection bit; STOP wins over a same-cycle write so it always re-arms
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      wp_en_q <= wp_gate_pkg::WP_EN_RESET; // RULE3
    end else if (CE) begin
      if (STOP_DET) begin
        wp_en_q <= wp_gate_pkg::WP_EN_RESET; // RULE3
      end else if (WR_STB && ctrl_hit) begin
        wp_en_q <= WR_DATA[wp_gate_pkg::WP_EN_BIT]; // RULE6
      end
    end
  end

  // Reserved storage, no functional effect
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      rsvd_q <= wp_gate_pkg::RSVD_RESET; // RULE5
    end else if (CE && WR_STB && ctrl_hit) begin
      rsvd_q <= WR_DATA[wp_gate_pkg::RSVD_HI:wp_gate_pkg::RSVD_LO]; // RULE5
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Forwarded write to the downstream register file, registered
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      REG_WR_STB <= 1'b0;
      REG_WR_ADDR <= '0;
      REG_WR_DATA <= '0;
    end else if (CE) begin
      REG_WR_STB <= pass; // RULE1 RULE2
      if (pass) begin
        REG_WR_ADDR <= WR_ADDR;
        REG_WR_DATA <= WR_DATA;
      end
    end
  end

  // Readback of the control register; blank bits read zero
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      RD_DATA <= '0;
      RD_HIT <= 1'b0;
    end else if (CE) begin
      RD_HIT <= rd_ctrl;
      if (rd_ctrl) begin
        RD_DATA <= rd_word; // RULE4
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  chk_no_protected_write: assert property (@(posedge CLK) disable iff (!RST_B)
    CE && WR_STB && !ctrl_hit && wp_en_q |=> !REG_WR_STB) // RULE1
    else $error("protected write forwarded");
  chk_open_write_commit: assert property (@(posedge CLK) // RULE2
    disable iff (!RST_B)
    CE && WR_STB && !ctrl_hit && !wp_en_q |=> REG_WR_STB
      && REG_WR_DATA == $past(WR_DATA) && REG_WR_ADDR == $past(WR_ADDR))
    else $error("open write not committed");
  chk_stop_rearms: assert property (@(posedge CLK) disable iff (!RST_B)
    CE && STOP_DET |=> WP_EN) // RULE3
    else $error("stop did not rearm");
  chk_reset_armed: assert property (@(posedge CLK)
    !RST_B |=> WP_EN && rsvd_q == wp_gate_pkg::RSVD_RESET) // RULE3
    else $error("reset value wrong");
  chk_blank_zero: assert property (@(posedge CLK) disable iff (!RST_B)
    RD_HIT |-> RD_DATA[7:4] == wp_gate_pkg::BLANK_READ) // RULE4
    else $error("blank bits nonzero");
  chk_rsvd_store: assert property (@(posedge CLK) disable iff (!RST_B)
    CE && WR_STB && ctrl_hit && !STOP_DET |=> rsvd_q == $past(WR_DATA[3:1])
      && WP_EN == $past(WR_DATA[0])) // RULE5
    else $error("ctrl write lost");
  chk_ctrl_unlock: assert property (@(posedge CLK) // RULE6
    disable iff (!RST_B)
    CE && WR_STB && ctrl_hit && WP_EN && !WR_DATA[0] && !STOP_DET |=> !WP_EN)
    else $error("unlock refused");
  chk_freeze: assert property (@(posedge CLK) disable iff (!RST_B)
    !CE |=> $stable(WP_EN) && $stable(REG_WR_STB))
    else $error("state moved without enable");

  ////////////////////////////////////////////////////////////////////////
  // Further checks on control storage, readback and forwarding

  // A control write is held here and never leaks downstream
  chk_ctrl_no_fwd: assert property (@(posedge CLK) // RULE6
    disable iff (!RST_B)
    CE && ctrl_wr |=> !REG_WR_STB)
    else $error("control write forwarded");

  // Nothing reaches the register file unless the gate is open
  chk_fwd_needs_pass: assert property (@(posedge CLK) // RULE1
    disable iff (!RST_B)
    CE && !pass |=> !REG_WR_STB)
    else $error("write forwarded without pass");

  // Forwarded address and data hold while no write passes
  chk_fwd_hold: assert property (@(posedge CLK)
    disable iff (!RST_B)
    CE && !pass |=> $stable(REG_WR_ADDR) && $stable(REG_WR_DATA))
    else $error("forwarded word moved");

  // A control read returns the live stored bits next cycle
  chk_rd_hit_set: assert property (@(posedge CLK) // RULE5
    disable iff (!RST_B)
    CE && rd_ctrl |=> RD_HIT && RD_DATA[3:0] == $past({rsvd_q, wp_en_q}))
    else $error("control read wrong");

  // No hit without a control read
  chk_rd_hit_clear: assert property (@(posedge CLK)
    disable iff (!RST_B)
    CE && !rd_ctrl |=> !RD_HIT)
    else $error("spurious read hit");

  // Blank bits always read as the fixed pattern
  chk_rd_blank: assert property (@(posedge CLK) // RULE4
    disable iff (!RST_B)
    CE && rd_ctrl |=> RD_DATA[7:4] == wp_gate_pkg::BLANK_READ)
    else $error("blank bits stored");

  // Protection moves only on STOP or a control write
  chk_wp_hold: assert property (@(posedge CLK) // RULE1
    disable iff (!RST_B)
    CE && !STOP_DET && !ctrl_wr |=> $stable(WP_EN))
    else $error("protection moved unasked");

  // Reserved bits move only on a control write
  chk_rsvd_hold: assert property (@(posedge CLK) // RULE5
    disable iff (!RST_B)
    CE && !ctrl_wr |=> $stable(rsvd_q))
    else $error("reserved bits moved");

  // STOP beats an unlock in the same cycle so the gate re-arms
  chk_stop_beats_write: assert property (@(posedge CLK) // RULE3
    disable iff (!RST_B)
    CE && STOP_DET && ctrl_wr |=> WP_EN)
    else $error("stop lost to write");

  // Reserved bits still land when STOP coincides
  chk_rsvd_on_stop: assert property (@(posedge CLK) // RULE5
    disable iff (!RST_B)
    CE && STOP_DET && ctrl_wr |=> rsvd_q ==
      $past(WR_DATA[wp_gate_pkg::RSVD_HI:wp_gate_pkg::RSVD_LO]))
    else $error("reserved bits lost on stop");

  // Frozen clock enable keeps readback still
  chk_freeze_read: assert property (@(posedge CLK)
    disable iff (!RST_B)
    !CE |=> $stable(RD_HIT) && $stable(RD_DATA) && $stable(rsvd_q))
    else $error("readback moved without enable");

  // Frozen clock enable keeps the forwarded word still
  chk_freeze_fwd: assert property (@(posedge CLK)
    disable iff (!RST_B)
    !CE |=> $stable(REG_WR_ADDR) && $stable(REG_WR_DATA))
    else $error("forward moved without enable");

  // Reset leaves both strobes low
  chk_reset_quiet: assert property (@(posedge CLK) // RULE3
    !RST_B |=> !REG_WR_STB && !RD_HIT)
    else $error("strobe high after reset");

  // Host may re-lock by writing the enable bit high
  chk_relock_write: assert property (@(posedge CLK) // RULE6
    disable iff (!RST_B)
    CE && ctrl_wr && WR_DATA[wp_gate_pkg::WP_EN_BIT] |=> WP_EN)
    else $error("relock refused");

  // Every open write to another address is forwarded
  chk_open_any_addr: assert property (@(posedge CLK) // RULE2
    disable iff (!RST_B)
    CE && WR_STB && !ctrl_hit && !WP_EN |=> REG_WR_STB)
    else $error("open write dropped");

endmodule

// >>> tb/host_model.sv
// Host model that turns bench ops into register strobes
`timescale 1ns/1ps
module host_model (
  input wire logic clk,
  input wire logic [1:0] op,
  output logic wr,
  output logic rd,
  output logic stp
);
  // Op 1 write, 2 read, 3 STOP, each strobe one cycle late
  always_ff @(posedge clk) {stp, rd, wr} <= 3'((4'h1 << op) >> 1);
endmodule

// >>> tb/i2c_register_write_protect_tb_top.sv
// Tests of the write-protect gate
`timescale 1ns/1ps
module i2c_register_write_protect_tb_top;
  logic CLK = 1'b0, RST_B = 1'b0, ce = 1'b1, w, rd, st, fw, wp;
  logic [17:0] c = 18'h0;
  logic [7:0] fd, rv;
  logic [31:0] x = 32'h1572;
  int n_fail, num_checks;
  host_model i_host(.clk(CLK), .op(c[17:16]), .wr(w), .rd(rd), .stp(st));
  wp_gate i_dut(.CLK(CLK), .RST_B(RST_B), .CE(ce), .WR_STB(w),
    .WR_ADDR(c[15:8]), .WR_DATA(c[7:0]), .RD_STB(rd), .RD_ADDR(c[15:8]),
    .STOP_DET(st), .REG_WR_STB(fw), .REG_WR_ADDR(), .REG_WR_DATA(fd),
    .RD_DATA(rv), .RD_HIT(), .WP_EN(wp));
  initial forever #2.5 CLK = ~CLK; // 200 MHz
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction
  task automatic chk(input string n, input logic [8:0] e, g);
    num_checks++;
    n_fail += g !== e;
    if (g !== e) $display("BAD %s exp %h got %h", n, e, g);
  endtask
  task automatic go(input logic [17:0] v);
    @(posedge CLK) c <= v;
    @(posedge CLK) c[17:16] <= 2'h0;
    @(posedge CLK) #1;
  endtask
  task automatic burst(input logic e);
    for (int i = 0; i < 6; i++) begin
      x = xs(x);
      go({2'h1, x[7:0] == 8'h14 ? 8'h15 : x[7:0], x[15:8]});
      chk("fwd", {e, e ? x[15:8] : 8'h0}, {fw, fw ? fd : 8'h0});
    end
    $display("burst %b done", e);
  endtask
  task automatic test_done;
    $display("checks %0d fails %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin // Protected, opened, then re-armed by STOP
    repeat (8) @(posedge CLK);
    RST_B <= 1'b1;
    burst(1'b0);
    go(18'h1140e);
    burst(1'b1);
    go(18'h30000);
    go(18'h21400);
    chk("ctl", 9'h00f, {1'b0, rv});
    ce <= 1'b0;
    go(18'h11400);
    chk("frz", 9'h001, {8'h0, wp});
    ce <= 1'b1;
    $display("freeze done");
    test_done;
  end
endmodule
